/* File: rtl/ulfpc_pkg.sv */
// Types of the line, flow and pin control block.
// Assumes ulfpc_regs.svh for numeric constants.
package ulfpc_pkg;
    typedef enum logic [2:0] {
        ULFPC_FLOW_NONE  = 3'h0,
        ULFPC_FLOW_HW    = 3'h1,
        ULFPC_FLOW_SW    = 3'h2,
        ULFPC_FLOW_MDRX  = 3'h3,
        ULFPC_FLOW_MDALL = 3'h4
    } ulfpc_flow_t;
    typedef enum logic [2:0] {
        ULFPC_PIN_GP     = 3'h0,
        ULFPC_PIN_RTSCTS = 3'h1,
        ULFPC_PIN_DTRDSR = 3'h2,
        ULFPC_PIN_DIR    = 3'h3,
        ULFPC_PIN_DIRADR = 3'h4
    } ulfpc_pinfn_t;
    typedef enum logic [1:0] {
        ULFPC_DIR_IDLE = 2'h0,
        ULFPC_DIR_TX   = 2'h1,
        ULFPC_DIR_HOLD = 2'h2
    } ulfpc_dir_t;
    typedef struct packed {
        logic       rx_valid;
        logic [7:0] rx_data;
        logic       brk_event;
        logic       brk_live;
        logic       frm_err;
        logic       par_err;
        logic       ovr_err;
    } ulfpc_rx_t;
endpackage : ulfpc_pkg

/* File: rtl/ulfpc_regs.svh */
// Register offsets, field positions and constants of the line, flow and pin control block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef ULFPC_REGS_SVH
`define ULFPC_REGS_SVH
`define ULFPC_OFF_PKT        12'h00C
`define ULFPC_OFF_LAT        12'h010
`define ULFPC_OFF_NTF        12'h018
`define ULFPC_OFF_FLOW       12'h040
`define ULFPC_OFF_RESUME     12'h044
`define ULFPC_OFF_PAUSE      12'h048
`define ULFPC_OFF_LOOP       12'h04C
`define ULFPC_OFF_ERR        12'h050
`define ULFPC_OFF_BRK        12'h054
`define ULFPC_OFF_TURN       12'h058
`define ULFPC_OFF_FUNC       12'h05C
`define ULFPC_OFF_DIR        12'h060
`define ULFPC_OFF_MASK       12'h064
`define ULFPC_OFF_SET        12'h068
`define ULFPC_OFF_CLR        12'h06C
`define ULFPC_OFF_LVL        12'h070
`define ULFPC_OFF_BAUD       12'h074
`define ULFPC_FLOW_HALF      3
`define ULFPC_LOOP_EN        2
`define ULFPC_ERR_BRK        3
`define ULFPC_ERR_FRM        4
`define ULFPC_ERR_PAR        5
`define ULFPC_ERR_OVR        6
`define ULFPC_ERR_LIVE       7
`define ULFPC_FUNC_POL       3
`define ULFPC_PKT_SIZE       1
`define ULFPC_PKT_LARGE      7'h40
`define ULFPC_PKT_SMALL      7'h3F
`define ULFPC_LAT_BAUD       32'h0000B749
`define ULFPC_TMO_CHARS      2'h3
`define ULFPC_ZERO8          8'h00
`endif

/* File: rtl/ulfpc_top.sv */
// Flow mode, address match, line error flags, break, transceiver direction, general
// pins, packet size and prompt receive forwarding of a USB-attached UART, on APB.
// Assumes a shifter and receiver outside; receive events arrive as one-cycle pulses.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "ulfpc_regs.svh"
// Functional notes
// - Mode 0 none; mode 2 software pause/resume.
// - Mode 1 hardware flow, pair by function.
// - Mode 3 receive only after address match.
// - Mode 4 both directions after match.
// - Half duplex ignores receive while transmitting.
// - Pause char halts, resume char restarts transmit.
// - Multidrop uses both chars as addresses.
// - Loop bit routes transmit into receive.
// - Sticky break flag, cleared by read.
// - Sticky framing and parity flags, read clears.
// - Sticky overrun flag, read clears.
// - Bit 7 shows break live.
// - Nonzero break register forces break after character.
// - Direction held turnaround bit times after transmit.
// - Function codes 0,1,2 assign pins.
// - Codes 3,4 make pin 5 direction.
// - Polarity bit sets direction level when transmitting.
// - Direction bits only steer general pins.
// - Masked input change raises notify pulse.
// - Set and clear registers drive latches.
// - Packet size bit, set on class command.
// - Low latency auto set below 46921 baud.
// - Withhold receive until packet or timeout.
module ulfpc_top #(
    parameter int NPINS = 6
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire ulfpc_pkg::ulfpc_rx_t rx_in,
    input  wire logic                serial_rx,
    input  wire logic                shifter_tx,
    input  wire logic                tx_busy,
    input  wire logic                bit_tick,
    input  wire logic                char_tick,
    input  wire logic                class_cmd,
    input  wire logic                bulk_in_req,
    input  wire logic [6:0]          rx_count,
    input  wire logic [NPINS-1:0]    aux_pin_in,
    output logic [NPINS-1:0]         aux_pin_out,
    output logic [NPINS-1:0]         aux_pin_oe_n,
    output logic                     serial_tx,
    output logic                     rx_line,
    output logic                     rx_accept,
    output logic [7:0]               rx_data,
    output logic                     tx_enable,
    output logic                     break_active,
    output logic                     rx_forward,
    output logic                     pin_notify,
    output logic [6:0]               max_bulk_packet_size
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] packet_and_wide_ctl, prompt_forward_ctl, notify_pin_select;
    logic [7:0] flow_mode_reg, resume_char, pause_char, internal_loop_ctl;
    logic [7:0] line_error_flags, send_break_ctl, turnaround_delay;
    logic [7:0] pin_function_select, pin_direction, pin_change_notify_mask;
    logic [NPINS-1:0] out_latch, pin_prev;
    logic [31:0] baud_rate;
    logic       paused, addr_matched, brk_engaged;
    logic [7:0] next_pkt, next_lat, next_ntf, next_flow, next_res, next_pau, next_loop;
    logic [7:0] next_err, next_brk, next_turn, next_func, next_dir, next_mask;
    logic [NPINS-1:0] next_latch;
    logic [31:0] next_baud, next_prdata;
    logic       next_paused, next_matched, next_engaged;
    logic       wr, rd, hit;
    ulfpc_pkg::ulfpc_flow_t  fmode;
    ulfpc_pkg::ulfpc_pinfn_t pfn;
    logic [NPINS-1:0] gp_mask;
    logic       rx_ok, is_md, rx_gate;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign fmode = ulfpc_pkg::ulfpc_flow_t'(flow_mode_reg[2:0]);
    assign pfn = ulfpc_pkg::ulfpc_pinfn_t'(pin_function_select[2:0]);
    assign is_md = (fmode == ulfpc_pkg::ULFPC_FLOW_MDRX) || (fmode == ulfpc_pkg::ULFPC_FLOW_MDALL);

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // Loop feeds serial_tx back, break included, half duplex blanks while transmitting
    assign rx_line = internal_loop_ctl[`ULFPC_LOOP_EN] ? serial_tx : serial_rx;
    assign rx_gate = flow_mode_reg[`ULFPC_FLOW_HALF] && tx_busy;
    assign rx_ok = rx_in.rx_valid && !rx_gate;
    always_comb begin
        next_paused  = paused;
        next_matched = addr_matched;
        if (rx_ok && fmode == ulfpc_pkg::ULFPC_FLOW_SW) begin
            if (rx_in.rx_data == pause_char) next_paused = 1'b1;
            else if (rx_in.rx_data == resume_char) next_paused = 1'b0;
        end
        if (!(fmode == ulfpc_pkg::ULFPC_FLOW_SW)) next_paused = 1'b0;
        // Data bytes after the address must not drop the match
        if (rx_ok && is_md && ((rx_in.rx_data == resume_char) || (rx_in.rx_data == pause_char)))
            next_matched = 1'b1;
        if (!is_md) next_matched = 1'b0;
    end
    // Address bytes themselves are not passed on
    assign rx_accept = rx_ok && (!is_md || (addr_matched &&
                       rx_in.rx_data != resume_char && rx_in.rx_data != pause_char));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_data <= `ULFPC_ZERO8;
        else if (rx_accept) rx_data <= rx_in.rx_data;
    end

    // ----------------------------------------------------------------
    // Transmit gating, hardware flow and break
    // ----------------------------------------------------------------
    logic peer_ready;
    always_comb begin
        peer_ready = 1'b1;
        if (fmode == ulfpc_pkg::ULFPC_FLOW_HW) begin
            if (pfn == ulfpc_pkg::ULFPC_PIN_RTSCTS) peer_ready = !aux_pin_in[4];
            else if (pfn == ulfpc_pkg::ULFPC_PIN_DTRDSR) peer_ready = !aux_pin_in[2];
        end
    end
    assign tx_enable = peer_ready && !paused && !brk_engaged && !send_break_ctl[0] &&
                       (send_break_ctl == `ULFPC_ZERO8) &&
                       (fmode != ulfpc_pkg::ULFPC_FLOW_MDALL || addr_matched);
    always_comb begin
        next_engaged = brk_engaged;
        if (send_break_ctl == `ULFPC_ZERO8) next_engaged = 1'b0;
        else if (!tx_busy) next_engaged = 1'b1;
    end
    assign break_active = brk_engaged;
    assign serial_tx = brk_engaged ? 1'b0 : shifter_tx;

    // ----------------------------------------------------------------
    // Transceiver direction
    // ----------------------------------------------------------------
    ulfpc_pkg::ulfpc_dir_t dstate, next_dstate;
    logic [3:0] dcnt, next_dcnt;
    logic dir_mode, dir_on;
    assign dir_mode = (pfn == ulfpc_pkg::ULFPC_PIN_DIR) ||
                      (pfn == ulfpc_pkg::ULFPC_PIN_DIRADR && addr_matched);
    always_comb begin
        next_dstate = dstate;
        next_dcnt   = dcnt;
        case (dstate)
            ulfpc_pkg::ULFPC_DIR_IDLE: if (tx_busy && dir_mode) next_dstate = ulfpc_pkg::ULFPC_DIR_TX;
            ulfpc_pkg::ULFPC_DIR_TX: begin
                if (!tx_busy) begin
                    next_dcnt   = turnaround_delay[3:0];
                    next_dstate = (turnaround_delay[3:0] == 4'h0) ?
                                  ulfpc_pkg::ULFPC_DIR_IDLE : ulfpc_pkg::ULFPC_DIR_HOLD;
                end
            end
            ulfpc_pkg::ULFPC_DIR_HOLD: begin
                if (tx_busy) next_dstate = ulfpc_pkg::ULFPC_DIR_TX;
                else if (bit_tick) begin
                    next_dcnt = dcnt - 4'h1;
                    if (dcnt == 4'h1) next_dstate = ulfpc_pkg::ULFPC_DIR_IDLE;
                end
            end
            default: next_dstate = ulfpc_pkg::ULFPC_DIR_IDLE;
        endcase
    end
    assign dir_on = (dstate != ulfpc_pkg::ULFPC_DIR_IDLE);

    // ----------------------------------------------------------------
    // Auxiliary pins
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            logic uart_fn;
            assign uart_fn = ((pfn == ulfpc_pkg::ULFPC_PIN_RTSCTS) && (gi == 4 || gi == 5)) ||
                             ((pfn == ulfpc_pkg::ULFPC_PIN_DTRDSR) && (gi == 2 || gi == 3)) ||
                             (dir_mode && gi == 5) ||
                             ((pfn == ulfpc_pkg::ULFPC_PIN_DIRADR) && gi == 5);
            assign gp_mask[gi] = !uart_fn;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    aux_pin_out[gi]  <= 1'b1;
                    aux_pin_oe_n[gi] <= 1'b1;
                end else if (uart_fn) begin
                    aux_pin_oe_n[gi] <= (gi == 4 || gi == 2);
                    if (gi == 5 && pfn >= ulfpc_pkg::ULFPC_PIN_DIR)
                        aux_pin_out[gi] <= dir_on ~^ pin_function_select[`ULFPC_FUNC_POL];
                    else
                        aux_pin_out[gi] <= !(rx_count < `ULFPC_PKT_SMALL);
                end else begin
                    aux_pin_oe_n[gi] <= !pin_direction[gi];
                    aux_pin_out[gi]  <= out_latch[gi];
                end
            end
        end
    endgenerate
    always_comb begin
        next_latch = out_latch;
        if (wr && paddr == `ULFPC_OFF_SET) next_latch = out_latch | pwdata[NPINS-1:0];
        if (wr && paddr == `ULFPC_OFF_CLR) next_latch = out_latch & ~pwdata[NPINS-1:0];
    end
    logic next_notify;
    assign next_notify = |((aux_pin_in ^ pin_prev) & gp_mask & ~pin_direction[NPINS-1:0] &
                           pin_change_notify_mask[NPINS-1:0]);

    // ----------------------------------------------------------------
    // Prompt forwarding
    // ----------------------------------------------------------------
    logic [1:0] tmo_cnt, next_tmo;
    always_comb begin
        next_tmo = tmo_cnt;
        if (rx_accept || rx_count == 7'h00) next_tmo = 2'h0;
        else if (char_tick && tmo_cnt != `ULFPC_TMO_CHARS) next_tmo = tmo_cnt + 2'h1;
    end
    assign max_bulk_packet_size = packet_and_wide_ctl[`ULFPC_PKT_SIZE] ?
                                  `ULFPC_PKT_SMALL : `ULFPC_PKT_LARGE;
    assign rx_forward = bulk_in_req && (rx_count != 7'h00) && (prompt_forward_ctl[0] ||
                        rx_count >= max_bulk_packet_size || tmo_cnt == `ULFPC_TMO_CHARS);

    // ----------------------------------------------------------------
    // Register writes and error flags
    // ----------------------------------------------------------------
    logic [7:0] errw;
    always_comb begin
        next_pkt = packet_and_wide_ctl; next_lat = prompt_forward_ctl;
        next_ntf = notify_pin_select;   next_flow = flow_mode_reg;
        next_res = resume_char;         next_pau = pause_char;
        next_loop = internal_loop_ctl;  next_brk = send_break_ctl;
        next_turn = turnaround_delay;   next_func = pin_function_select;
        next_dir = pin_direction;       next_mask = pin_change_notify_mask;
        next_baud = baud_rate;
        if (wr) begin
            case (paddr)
                `ULFPC_OFF_PKT:    next_pkt  = {6'h00, pwdata[1:0]};
                `ULFPC_OFF_LAT:    next_lat  = {7'h00, pwdata[0]};
                `ULFPC_OFF_NTF:    next_ntf  = {1'b0, pwdata[6:3], 1'b0, pwdata[1:0]};
                `ULFPC_OFF_FLOW:   next_flow = {4'h0, pwdata[3:0]};
                `ULFPC_OFF_RESUME: next_res  = pwdata[7:0];
                `ULFPC_OFF_PAUSE:  next_pau  = pwdata[7:0];
                `ULFPC_OFF_LOOP:   next_loop = {5'h00, pwdata[2], 2'h0};
                `ULFPC_OFF_BRK:    next_brk  = pwdata[7:0];
                `ULFPC_OFF_TURN:   next_turn = {4'h0, pwdata[3:0]};
                `ULFPC_OFF_FUNC:   next_func = {4'h0, pwdata[3:0]};
                `ULFPC_OFF_DIR:    next_dir  = {2'h0, pwdata[5:0]};
                `ULFPC_OFF_MASK:   next_mask = {2'h0, pwdata[5:0]};
                `ULFPC_OFF_BAUD: begin
                    next_baud = pwdata;
                    next_lat  = {7'h00, (pwdata < `ULFPC_LAT_BAUD)};
                end
                default: ;
            endcase
        end
        if (class_cmd) next_pkt[`ULFPC_PKT_SIZE] = 1'b1;
        // Read clears sticky flags; a same-cycle event still sets
        errw = (rd && paddr == `ULFPC_OFF_ERR) ? `ULFPC_ZERO8 : line_error_flags;
        next_err = errw;
        if (rx_in.brk_event) next_err[`ULFPC_ERR_BRK] = 1'b1;
        if (rx_in.frm_err && !rx_gate) next_err[`ULFPC_ERR_FRM] = 1'b1;
        if (rx_in.par_err && !rx_gate) next_err[`ULFPC_ERR_PAR] = 1'b1;
        if (rx_in.ovr_err) next_err[`ULFPC_ERR_OVR] = 1'b1;
        next_err[`ULFPC_ERR_LIVE] = rx_in.brk_live;
        next_err[2:0] = 3'h0;
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [NPINS-1:0] lvl;
    assign lvl = aux_pin_in;
    always_comb begin
        next_prdata = 32'h00000000;
        case (paddr)
            `ULFPC_OFF_PKT:    next_prdata[7:0] = packet_and_wide_ctl;
            `ULFPC_OFF_LAT:    next_prdata[7:0] = prompt_forward_ctl;
            `ULFPC_OFF_NTF:    next_prdata[7:0] = notify_pin_select;
            `ULFPC_OFF_FLOW:   next_prdata[7:0] = flow_mode_reg;
            `ULFPC_OFF_RESUME: next_prdata[7:0] = resume_char;
            `ULFPC_OFF_PAUSE:  next_prdata[7:0] = pause_char;
            `ULFPC_OFF_LOOP:   next_prdata[7:0] = internal_loop_ctl;
            `ULFPC_OFF_ERR:    next_prdata[7:0] = line_error_flags;
            `ULFPC_OFF_BRK:    next_prdata[7:0] = send_break_ctl;
            `ULFPC_OFF_TURN:   next_prdata[7:0] = turnaround_delay;
            `ULFPC_OFF_FUNC:   next_prdata[7:0] = pin_function_select;
            `ULFPC_OFF_DIR:    next_prdata[NPINS-1:0] = pin_direction[NPINS-1:0] & gp_mask;
            `ULFPC_OFF_MASK:   next_prdata[7:0] = pin_change_notify_mask;
            `ULFPC_OFF_LVL:    next_prdata[NPINS-1:0] = lvl;
            `ULFPC_OFF_BAUD:   next_prdata = baud_rate;
            default: ;
        endcase
    end
    assign prdata = next_prdata;

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            packet_and_wide_ctl <= `ULFPC_ZERO8; prompt_forward_ctl <= `ULFPC_ZERO8;
            notify_pin_select <= `ULFPC_ZERO8;   flow_mode_reg <= `ULFPC_ZERO8;
            resume_char <= `ULFPC_ZERO8;         pause_char <= `ULFPC_ZERO8;
            internal_loop_ctl <= `ULFPC_ZERO8;   line_error_flags <= `ULFPC_ZERO8;
            send_break_ctl <= `ULFPC_ZERO8;      turnaround_delay <= `ULFPC_ZERO8;
            pin_function_select <= `ULFPC_ZERO8; pin_direction <= `ULFPC_ZERO8;
            pin_change_notify_mask <= `ULFPC_ZERO8;
            out_latch <= '1;  pin_prev <= '0;  pin_notify <= 1'b0;
            baud_rate <= 32'h00000000;
            paused <= 1'b0;  addr_matched <= 1'b0;  brk_engaged <= 1'b0;
            dstate <= ulfpc_pkg::ULFPC_DIR_IDLE;  dcnt <= 4'h0;  tmo_cnt <= 2'h0;
        end else begin
            packet_and_wide_ctl <= next_pkt;  prompt_forward_ctl <= next_lat;
            notify_pin_select <= next_ntf;    flow_mode_reg <= next_flow;
            resume_char <= next_res;          pause_char <= next_pau;
            internal_loop_ctl <= next_loop;   line_error_flags <= next_err;
            send_break_ctl <= next_brk;       turnaround_delay <= next_turn;
            pin_function_select <= next_func; pin_direction <= next_dir;
            pin_change_notify_mask <= next_mask;
            out_latch <= next_latch;  pin_prev <= aux_pin_in;  pin_notify <= next_notify;
            baud_rate <= next_baud;
            paused <= next_paused;  addr_matched <= next_matched;  brk_engaged <= next_engaged;
            dstate <= next_dstate;  dcnt <= next_dcnt;  tmo_cnt <= next_tmo;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_pause_halts: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_ok && fmode == ulfpc_pkg::ULFPC_FLOW_SW && rx_in.rx_data == pause_char)
        |=> !tx_enable) else $error("pause char did not halt transmit");
    a_loop_route: assert property (@(posedge pclk) disable iff (!presetn)
        internal_loop_ctl[`ULFPC_LOOP_EN] |-> (rx_line == serial_tx))
        else $error("loop not routing transmit");
    a_brk_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        rx_in.brk_event |=> line_error_flags[`ULFPC_ERR_BRK]) else $error("break flag lost");
    a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && paddr == `ULFPC_OFF_ERR && !rx_in.frm_err) |=> !line_error_flags[`ULFPC_ERR_FRM])
        else $error("framing flag not cleared");
    a_ovr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        rx_in.ovr_err |=> line_error_flags[`ULFPC_ERR_OVR]) else $error("overrun flag lost");
    a_brk_live: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 line_error_flags[`ULFPC_ERR_LIVE] == $past(rx_in.brk_live))
        else $error("live break mismatch");
    a_brk_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (send_break_ctl != `ULFPC_ZERO8 && !tx_busy) |=> !serial_tx)
        else $error("break not driven");
    a_half_block: assert property (@(posedge pclk) disable iff (!presetn)
        (flow_mode_reg[`ULFPC_FLOW_HALF] && tx_busy) |-> !rx_accept)
        else $error("receive accepted in half duplex");
    a_pkt_size: assert property (@(posedge pclk) disable iff (!presetn)
        class_cmd |=> max_bulk_packet_size == `ULFPC_PKT_SMALL) else $error("packet size");
    a_md_tx: assert property (@(posedge pclk) disable iff (!presetn)
        (fmode == ulfpc_pkg::ULFPC_FLOW_MDALL && !addr_matched) |-> !tx_enable)
        else $error("transmit before address match");
endmodule : ulfpc_top

/* File: verif/tb.sv */
// Self-checking bench of the line, flow and pin control block over APB.
// Assumes the peer model for receive status and a zero-wait APB slave.
`timescale 1ns/1ps
`include "ulfpc_regs.svh"
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, live = 0;
    logic        serial_rx = 1, shifter_tx = 1, tx_busy = 0, bit_tick = 0, char_tick = 0;
    logic        class_cmd = 0, bulk_in_req = 0, pready, pslverr, serial_tx, rx_line;
    logic        rx_accept, tx_enable, break_active, rx_forward, pin_notify;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [6:0]  rx_count = 0, max_bulk_packet_size;
    logic [5:0]  aux_pin_in = 0, aux_pin_out, aux_pin_oe_n;
    logic [3:0]  ev = 0;
    logic [8:0]  byte_in = 0;
    logic [7:0]  rx_data;
    ulfpc_pkg::ulfpc_rx_t rx_in;
    int          n_fail = 0, n_compared = 0, k;
    ulfpc_top  ulfpc_top_inst (.*);
    ulfpc_peer ulfpc_peer_inst (.*);
    always #2.5 pclk = ~pclk;
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic ap(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask : ap
    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc
    task automatic send(logic [7:0] b);
        byte_in <= {1'b1, b};
        cyc(1);
        byte_in <= 0;
        cyc(2);
    endtask : send
    task automatic notes(logic [5:0] v);
        k = 0;
        aux_pin_in <= v;
        repeat (6) begin
            cyc(1);
            if (pin_notify === 1'b1) k++;
        end
    endtask : notes
    task summarize;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        cyc(1);
        chk("oe_n", aux_pin_oe_n, 32'h3F);
        chk("pkt", max_bulk_packet_size, 32'h40);
        ap(0, 12'hFFC, 0);
        chk("unmapped", r, 32'h0);
        class_cmd <= 1;
        cyc(1);
        class_cmd <= 0;
        cyc(2);
        chk("pkt63", max_bulk_packet_size, 32'h3F);
        ap(1, `ULFPC_OFF_BAUD, 32'h0000B748);
        ap(0, `ULFPC_OFF_LAT, 0);
        chk("lat_lo", r, 32'h1);
        ap(1, `ULFPC_OFF_BAUD, 32'h0000B749);
        ap(0, `ULFPC_OFF_LAT, 0);
        chk("lat_hi", r, 32'h0);
        ev <= 4'hF;
        live <= 1;
        @(posedge pclk);
        ev <= 0;
        cyc(3);
        ap(0, `ULFPC_OFF_ERR, 0);
        chk("err_set", r, 32'hF8);
        ap(0, `ULFPC_OFF_ERR, 0);
        chk("err_clr", r, 32'h80);
        live <= 0;
        cyc(3);
        ap(0, `ULFPC_OFF_ERR, 0);
        chk("err_off", r, 32'h0);
        ap(1, `ULFPC_OFF_LOOP, 32'h4);
        shifter_tx <= 0;
        cyc(1);
        chk("loop_on", rx_line, 32'h0);
        ap(1, `ULFPC_OFF_LOOP, 0);
        cyc(1);
        chk("loop_off", rx_line, 32'h1);
        shifter_tx <= 1;
        tx_busy <= 1;
        ap(1, `ULFPC_OFF_BRK, 32'h1);
        cyc(2);
        chk("brk_wait", serial_tx, 32'h1);
        tx_busy <= 0;
        cyc(2);
        chk("brk_on", serial_tx, 32'h0);
        ap(1, `ULFPC_OFF_BRK, 0);
        cyc(2);
        chk("brk_off", serial_tx, 32'h1);
        ap(1, `ULFPC_OFF_SET, 32'h3F);
        ap(1, `ULFPC_OFF_DIR, 32'h3F);
        cyc(2);
        chk("pin_out", aux_pin_out, 32'h3F);
        chk("pin_oe", aux_pin_oe_n, 32'h0);
        ap(1, `ULFPC_OFF_CLR, 32'h5);
        ap(1, `ULFPC_OFF_DIR, 0);
        ap(1, `ULFPC_OFF_DIR, 32'h3F);
        cyc(2);
        chk("pin_keep", aux_pin_out, 32'h3A);
        ap(1, `ULFPC_OFF_DIR, 0);
        ap(1, `ULFPC_OFF_MASK, 32'h1);
        notes(6'h01);
        chk("notify", k, 1);
        ap(1, `ULFPC_OFF_MASK, 0);
        notes(6'h00);
        chk("quiet", k, 0);
        ap(1, `ULFPC_OFF_FLOW, 32'h2);
        ap(1, `ULFPC_OFF_PAUSE, 32'h13);
        ap(1, `ULFPC_OFF_RESUME, 32'h11);
        send(8'h13);
        chk("paused", tx_enable, 32'h0);
        send(8'h11);
        chk("resumed", tx_enable, 32'h1);
        chk("rx_sw", rx_data, 32'h11);
        ap(1, `ULFPC_OFF_FLOW, 32'h4);
        cyc(1);
        chk("md_tx", tx_enable, 32'h0);
        send(8'h5A);
        chk("md_drop", rx_data, 32'h11);
        send(8'h13);
        send(8'h5A);
        send(8'hA5);
        chk("md_rx", rx_data, 32'hA5);
        chk("md_tx_on", tx_enable, 32'h1);
        ap(1, `ULFPC_OFF_TURN, 32'h2);
        ap(1, `ULFPC_OFF_FUNC, 32'h3);
        cyc(2);
        chk("dir_idle", aux_pin_out[5], 32'h1);
        tx_busy <= 1;
        cyc(3);
        chk("dir_tx", aux_pin_out[5], 32'h0);
        tx_busy <= 0;
        cyc(3);
        chk("dir_hold", aux_pin_out[5], 32'h0);
        bit_tick <= 1;
        cyc(2);
        bit_tick <= 0;
        cyc(3);
        chk("dir_off", aux_pin_out[5], 32'h1);
        bulk_in_req <= 1;
        rx_count <= 7'h05;
        cyc(1);
        chk("fwd_hold", rx_forward, 32'h0);
        ap(1, `ULFPC_OFF_LAT, 32'h1);
        cyc(1);
        chk("fwd_now", rx_forward, 32'h1);
        summarize();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        summarize();
    end
endmodule : tb

/* File: verif/ulfpc_peer.sv */
// Serial line peer: turns bench event requests into receive status pulses.
// Assumes the bench holds each request for one clock cycle.
`timescale 1ns/1ps
module ulfpc_peer (
    input  wire logic             pclk,
    input  wire logic [3:0]       ev,
    input  wire logic             live,
    input  wire logic [8:0]       byte_in,
    output ulfpc_pkg::ulfpc_rx_t  rx_in
);
    // Break, framing, parity and overrun events as one-cycle pulses
    always_ff @(posedge pclk) begin
        rx_in <= '{byte_in[8], byte_in[7:0], ev[0], live, ev[1], ev[2], ev[3]};
    end
endmodule : ulfpc_peer
